// ==== src/rrtc_pkg.sv ====
// package: constants, register map and carrier types of the run and ramp time controller
package rrtc_pkg;
  // ==========================================================================
  // clock and timing
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int SETTLE_STEP_MS = 1;
  localparam int CYC_PER_MS = CLK_FREQ_HZ / 1000 * SETTLE_STEP_MS;
  localparam int UNIT_FINE_MS = 10;
  localparam int CYC_PER_FINE = CLK_FREQ_HZ / 1000 * UNIT_FINE_MS;
  // one cycle longer than the pin synchroniser, so the power-up decision sees settled pins
  localparam logic [2:0] STARTUP_CYC = 3'h5;
  // ==========================================================================
  // widths and limits
  localparam int FW = 16;
  localparam int NUM_TIMES = 8;
  localparam int IRQ_W = 4;
  localparam logic [15:0] TIME_MAX = 16'h1770;
  localparam logic [15:0] SETTLE_MIN = 16'h0001;
  localparam logic [15:0] SETTLE_MAX = 16'h1388;
  localparam logic [1:0] SRC_TERM_ONE = 2'h1;
  localparam logic [1:0] SRC_TERM_TWO = 2'h2;
  localparam logic [1:0] UNIT_FINE = 2'h0;
  localparam logic [1:0] UNIT_COARSE = 2'h2;
  localparam int SEARCH_PWRUP_BIT = 4;
  localparam int SEARCH_RESTART_BIT = 2;
  // interrupt bit positions
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_START = 1;
  localparam int IRQ_SET = 2;
  localparam int IRQ_REACH = 3;
  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MAX_FREQ = 8'h04;
  localparam logic [7:0] OFS_TARGET = 8'h08;
  localparam logic [7:0] OFS_SWITCH_FREQ = 8'h0C;
  localparam logic [7:0] OFS_SETTLE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_OUT_FREQ = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFS_TIME0 = 8'h40;
  // ==========================================================================
  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0021;
  localparam logic [15:0] MAX_FREQ_RST = 16'h1770;
  localparam logic [15:0] SWITCH_FREQ_RST = 16'h0BB8;
  localparam logic [15:0] SETTLE_RST = 16'h0001;
  localparam logic [15:0] TIME_RST = 16'h00C8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // carrier types
  typedef struct packed {
    logic [7:0] search_cfg;
    logic xcel_term;
    logic [1:0] time_unit;
    logic ramp_basis;
    logic restart_en;
    logic pwr_on_run;
    logic [1:0] cmd_src;
  } rrtc_ctrl_s;
  typedef struct packed {
    logic xcel_m;
    logic xcel_l;
    logic rx;
    logic fx;
  } rrtc_term_s;
endpackage : rrtc_pkg

// ==== src/rrtc_sync.sv ====
// three-stage pin synchroniser; a change is taken once stages two and three agree
module rrtc_sync #(
  parameter int W = 4
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // ==========================================================================
  // per bit: stage one feeds only stage two, so no logic sees a metastable value
  always_comb begin
    for (int b = 0; b < W; b++) begin
      q_nxt[b] = (s2_r[b] == s3_r[b]) ? s3_r[b] : q_r[b];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r;
endmodule : rrtc_sync

// ==== src/rrtc_top.sv ====
// run command, restart and ramp time control with an axi4-lite register slave
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
module rrtc_top
  import rrtc_pkg::*;
#(
  parameter int P_CYC_PER_MS = CYC_PER_MS,
  parameter int P_CYC_PER_FINE = CYC_PER_FINE
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_fx,
  input wire logic i_rx,
  input wire logic i_xcel_l,
  input wire logic i_xcel_m,
  input wire logic i_trip,
  input wire logic i_trip_clr,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_run,
  output logic o_reverse,
  output logic o_drive_en,
  output logic o_search,
  output logic [FW-1:0] o_freq,
  output logic o_irq
);
  // ==========================================================================
  // functions
  function automatic logic [FW-1:0] absdiff(input logic [FW-1:0] a, input logic [FW-1:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : absdiff

  function automatic logic [15:0] rescale(input logic [15:0] v, input logic [1:0] from, input logic [1:0] to);
    logic [31:0] w;
    w = {16'h0000, v};
    if (to < from) begin
      w = (from - to == 2'h2) ? w * 32'd100 : w * 32'd10;
    end else if (to > from) begin
      w = (to - from == 2'h2) ? w / 32'd100 : w / 32'd10;
    end
    return (w > {16'h0000, TIME_MAX}) ? TIME_MAX : w[15:0];
  endfunction : rescale

  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  // ==========================================================================
  // registers
  rrtc_ctrl_s ctrl_r;
  logic [FW-1:0] max_r, tgt_r, swf_r, settle_r, freq_r, span_r, last_tgt_r;
  logic [15:0] time_r [NUM_TIMES];
  logic [IRQ_W-1:0] irq_st_r, irq_mask_r, irq_ev;
  logic [2:0] startup_r;
  logic armed_r, trip_r, run_r, srch_kind_r, search_r, drive_r, rev_r, irq_r, pwr_pend_r;
  logic [1:0] set_r, xin_last_r, set_prev_r;
  logic [31:0] settle_cnt_r;
  logic [47:0] acc_r;
  logic aw_have_r, w_have_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [1:0] bresp_r, rresp_r;
  rrtc_term_s term;

  rrtc_sync #(.W(4)) u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d({i_xcel_m, i_xcel_l, i_rx, i_fx}),
    .o_q(term)
  );

  // ==========================================================================
  // run command decode
  wire src_one = ctrl_r.cmd_src == SRC_TERM_ONE;
  wire src_term = src_one || ctrl_r.cmd_src == SRC_TERM_TWO;
  wire cmd_act = src_one ? (term.fx ^ term.rx) : (src_term & term.fx);
  wire startup_end = startup_r == 3'h1;
  wire booted = startup_r == 3'h0;
  wire clr_trip = trip_r & i_trip_clr;
  wire pwr_start = pwr_pend_r & ctrl_r.pwr_on_run & src_term & cmd_act;
  wire rst_start = clr_trip & ctrl_r.restart_en & src_term & cmd_act;
  wire trip_nxt = i_trip | (trip_r & ~i_trip_clr);
  wire armed_nxt = pwr_start | rst_start | ~cmd_act |
    (armed_r & ~clr_trip & ~startup_end);
  wire run_nxt = booted & armed_nxt & cmd_act & ~trip_nxt;

  // ==========================================================================
  // ramp set selection and settle window
  wire [1:0] xin = {term.xcel_m, term.xcel_l};
  wire xin_chg = xin != xin_last_r;
  wire [1:0] sel_set = ctrl_r.xcel_term ? set_r : ((freq_r < swf_r) ? 2'h1 : 2'h0);

  // ==========================================================================
  // ramp generator
  wire [FW-1:0] eff_tgt = run_r ? ((tgt_r > max_r) ? max_r : tgt_r) : '0;
  wire rising = freq_r < eff_tgt;
  wire [15:0] tsel = time_r[{sel_set, ~rising}];
  wire [47:0] unit_cyc = (ctrl_r.time_unit == UNIT_FINE) ? 48'(P_CYC_PER_FINE) :
    ((ctrl_r.time_unit == UNIT_COARSE) ? 48'(P_CYC_PER_FINE) * 48'd100 : 48'(P_CYC_PER_FINE) * 48'd10);
  wire [47:0] thr = 48'(tsel) * unit_cyc;
  wire [FW-1:0] span = ctrl_r.ramp_basis ? span_r : max_r;
  wire [47:0] acc_sum = acc_r + 48'(span);
  wire step = acc_sum >= thr;
  wire reached = freq_r == eff_tgt;

  // ==========================================================================
  // axi4-lite decode
  wire wr_go = aw_have_r & w_have_r & ~bvalid_r;
  wire rd_go = i_arvalid & arready_r;
  wire [7:0] tofs = awaddr_r - OFS_TIME0;
  wire wr_time = awaddr_r >= OFS_TIME0 && awaddr_r < OFS_TIME0 + 8'(4 * NUM_TIMES) && awaddr_r[1:0] == 2'h0;
  wire wr_hit = wr_time || awaddr_r inside {OFS_CTRL, OFS_MAX_FREQ, OFS_TARGET, OFS_SWITCH_FREQ,
    OFS_SETTLE, OFS_STATUS, OFS_OUT_FREQ, OFS_IRQ_STAT, OFS_IRQ_MASK};
  wire [15:0] wv = wdata_r[15:0]; // strobes applied at capture, the master may move them after
  wire [7:0] rofs = i_araddr - OFS_TIME0;
  wire rd_time = i_araddr >= OFS_TIME0 && i_araddr < OFS_TIME0 + 8'(4 * NUM_TIMES) && i_araddr[1:0] == 2'h0;
  wire rd_stat = rd_go && i_araddr == OFS_IRQ_STAT;
  wire [31:0] status_w = {22'h0, set_r, sel_set, srch_kind_r, armed_r, trip_r, drive_r, run_r, reached};
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;
    if (rd_time) begin
      rd_val = {16'h0000, time_r[rofs[4:2]]};
    end else begin
      unique case (i_araddr)
        OFS_CTRL: rd_val = {16'h0000, ctrl_r};
        OFS_MAX_FREQ: rd_val = {16'h0000, max_r};
        OFS_TARGET: rd_val = {16'h0000, tgt_r};
        OFS_SWITCH_FREQ: rd_val = {16'h0000, swf_r};
        OFS_SETTLE: rd_val = {16'h0000, settle_r};
        OFS_STATUS: rd_val = status_w;
        OFS_OUT_FREQ: rd_val = {16'h0000, freq_r};
        OFS_IRQ_STAT: rd_val = {28'h0, irq_st_r};
        OFS_IRQ_MASK: rd_val = {28'h0, irq_mask_r};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // interrupt events; a read clears, but an event in the same cycle stays set
  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_TRIP] = i_trip & ~trip_r;
    irq_ev[IRQ_START] = run_nxt & ~run_r;
    irq_ev[IRQ_SET] = sel_set != set_prev_r;
    irq_ev[IRQ_REACH] = run_r & reached & (last_tgt_r != freq_r || acc_r != '0);
  end
  wire [IRQ_W-1:0] irq_st_nxt = (irq_st_r & ~(rd_stat ? {IRQ_W{1'b1}} : '0)) | irq_ev;

  // ==========================================================================
  // bus slave
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      if (i_awvalid & awready_r) begin
        aw_have_r <= 1'b1;
        awaddr_r <= i_awaddr;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (i_wvalid & wready_r) begin
        w_have_r <= 1'b1;
        wdata_r <= i_wdata & {{8{i_wstrb[3]}}, {8{i_wstrb[2]}}, {8{i_wstrb[1]}}, {8{i_wstrb[0]}}};
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
      awready_r <= ~aw_have_r & ~(i_awvalid & awready_r) & ~bvalid_r;
      wready_r <= ~w_have_r & ~(i_wvalid & wready_r) & ~bvalid_r;
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (i_bready) begin
        bvalid_r <= 1'b0;
      end
      arready_r <= ~rvalid_r & ~rd_go;
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_val;
        rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (i_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // configuration registers; a unit change rescales every stored time
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_r <= CTRL_RST;
      max_r <= MAX_FREQ_RST;
      tgt_r <= '0;
      swf_r <= SWITCH_FREQ_RST;
      settle_r <= SETTLE_RST;
      irq_mask_r <= '0;
      for (int i = 0; i < NUM_TIMES; i++) begin
        time_r[i] <= TIME_RST;
      end
    end else if (wr_go) begin
      if (wr_time) begin
        time_r[tofs[4:2]] <= clamp(wv, 16'h0000, TIME_MAX);
      end
      unique case (awaddr_r)
        OFS_CTRL: begin
          ctrl_r <= wv;
          ctrl_r.time_unit <= (wv[6:5] > UNIT_COARSE) ? UNIT_COARSE : wv[6:5];
          for (int i = 0; i < NUM_TIMES; i++) begin
            time_r[i] <= rescale(time_r[i], ctrl_r.time_unit,
              (wv[6:5] > UNIT_COARSE) ? UNIT_COARSE : wv[6:5]);
          end
        end
        OFS_MAX_FREQ: max_r <= wv;
        OFS_TARGET: tgt_r <= wv;
        OFS_SWITCH_FREQ: swf_r <= wv;
        OFS_SETTLE: settle_r <= clamp(wv, SETTLE_MIN, SETTLE_MAX);
        OFS_IRQ_MASK: irq_mask_r <= wv[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // run sequencing, settle window and ramp
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      startup_r <= STARTUP_CYC;
      armed_r <= 1'b0;
      pwr_pend_r <= 1'b0;
      trip_r <= 1'b0;
      run_r <= 1'b0;
      srch_kind_r <= 1'b0;
      search_r <= 1'b0;
      drive_r <= 1'b0;
      rev_r <= 1'b0;
      irq_st_r <= '0;
      irq_r <= 1'b0;
      set_r <= 2'h0;
      set_prev_r <= 2'h0;
      xin_last_r <= 2'h0;
      settle_cnt_r <= '0;
      freq_r <= '0;
      acc_r <= '0;
      span_r <= '0;
      last_tgt_r <= '0;
    end else begin
      // pins settle in the synchroniser before power-up state is judged
      startup_r <= booted ? 3'h0 : startup_r - 3'h1;
      armed_r <= armed_nxt;
      pwr_pend_r <= (startup_end | pwr_pend_r) & cmd_act & ~pwr_start & ~trip_nxt; // lasts while held from power-up
      trip_r <= trip_nxt;
      run_r <= run_nxt;
      rev_r <= term.rx;
      if (pwr_start) begin
        srch_kind_r <= ctrl_r.search_cfg[SEARCH_PWRUP_BIT];
      end else if (rst_start) begin
        srch_kind_r <= ctrl_r.search_cfg[SEARCH_RESTART_BIT];
      end else if (!cmd_act) begin
        srch_kind_r <= 1'b0;
      end
      search_r <= run_nxt & ~run_r & srch_kind_r | run_nxt & ~run_r & (pwr_start | rst_start) &
        ctrl_r.search_cfg[pwr_start ? SEARCH_PWRUP_BIT : SEARCH_RESTART_BIT];
      drive_r <= ~trip_nxt & (run_nxt | freq_r != '0);
      irq_st_r <= irq_st_nxt;
      irq_r <= |(irq_st_nxt & irq_mask_r);
      set_prev_r <= sel_set;
      // every select change restarts the window, so a late second pin is seen too
      xin_last_r <= xin;
      if (xin_chg) begin
        settle_cnt_r <= 32'(settle_r) * 32'(P_CYC_PER_MS);
      end else if (settle_cnt_r == 32'h0000_0001) begin
        settle_cnt_r <= '0;
        set_r <= xin;
      end else if (settle_cnt_r != '0) begin
        settle_cnt_r <= settle_cnt_r - 32'h0000_0001;
      end
      if (eff_tgt != last_tgt_r) begin
        last_tgt_r <= eff_tgt;
        span_r <= absdiff(eff_tgt, freq_r);
      end
      // coasting on trip: output frequency drops to zero, no ramp
      if (trip_r) begin
        freq_r <= '0;
        acc_r <= '0;
      end else if (reached) begin
        acc_r <= '0;
      end else if (tsel == 16'h0000) begin
        freq_r <= eff_tgt;
        acc_r <= '0;
      end else if (step) begin
        acc_r <= acc_sum - thr;
        freq_r <= rising ? freq_r + 16'h0001 : freq_r - 16'h0001;
      end else begin
        acc_r <= acc_sum;
      end
    end
  end

  assign o_awready = awready_r;
  assign o_wready = wready_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_arready = arready_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
  assign o_run = run_r;
  assign o_reverse = rev_r;
  assign o_drive_en = drive_r;
  assign o_search = search_r;
  assign o_freq = freq_r;
  assign o_irq = irq_r;
endmodule : rrtc_top

// ==== testbench/rrtc_sva.sv ====
// checker of the run and ramp time controller ports
module rrtc_sva
  import rrtc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_trip,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_run,
  input wire logic o_drive_en,
  input wire logic o_search,
  input wire logic [FW-1:0] o_freq
);
  // ==========================================================================
  // assertions
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  drive_cut_a: assert property (i_trip |-> ##[1:2] !o_drive_en)
    else $error("drive stayed enabled after trip");
  freq_clear_a: assert property (i_trip |-> ##2 (o_freq == 16'h0000))
    else $error("frequency not cleared after trip");
  search_start_a: assert property (o_search |-> o_run)
    else $error("search pulse without run");
  search_pulse_a: assert property (o_search |=> !o_search)
    else $error("search pulse longer than one cycle");
  write_answer_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid)
    else $error("write response missing");
  read_answer_a: assert property (i_arvalid && o_arready |-> ##[1:2] o_rvalid)
    else $error("read response missing");
  write_busy_a: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while response pending");
  read_busy_a: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted while data pending");
  slverr_zero_a: assert property (o_rvalid && o_rresp == RESP_SLVERR |-> o_rdata == 32'h0000_0000)
    else $error("error read returned data");
endmodule : rrtc_sva

bind rrtc_top rrtc_sva i_sva (.i_clk, .i_nrst, .i_trip, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
  .o_bvalid, .i_arvalid, .o_arready, .o_rvalid, .o_rdata, .o_rresp, .o_run, .o_drive_en, .o_search, .o_freq);

// ==== testbench/rrtc_seq_model.sv ====
// external sequence model driving the terminal pins
module rrtc_seq_model
  import rrtc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_fx,
  input wire logic i_rx,
  input wire logic [1:0] i_sel,
  output rrtc_term_s o_term
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // pins change only after a rising edge
  rrtc_term_s term_r = '0;
  // re-arming needs the run request off then on again, made from the requests
  // both select pins move in one edge so the settle window sees one change
  always @(posedge i_clk) begin
    term_r.fx <= i_fx;
    term_r.rx <= i_rx;
    term_r.xcel_l <= i_sel[0];
    term_r.xcel_m <= i_sel[1];
  end
  assign o_term = term_r;
endmodule : rrtc_seq_model

// ==== testbench/testbench.sv ====
// self-checking bench of the run and ramp time controller
module testbench
  import rrtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // signals and instances
  logic i_clk, i_nrst, i_trip, i_trip_clr, fx_q, rx_q;
  logic [1:0] sel_q, rr, o_bresp, o_rresp, prev;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rv, seed;
  logic [3:0] i_wstrb;
  logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic o_run, o_reverse, o_drive_en, o_search, o_irq;
  logic [FW-1:0] o_freq;
  rrtc_term_s term;
  int n_fail, n_tests, cyc, n_srch, n0;
  rrtc_seq_model i_seq (.i_clk, .i_fx(fx_q), .i_rx(rx_q), .i_sel(sel_q), .o_term(term));
  // short counts keep the ramps within about ten thousand cycles
  rrtc_top #(.P_CYC_PER_MS(10), .P_CYC_PER_FINE(100)) i_dut (
    .i_clk, .i_nrst, .i_fx(term.fx), .i_rx(term.rx), .i_xcel_l(term.xcel_l), .i_xcel_m(term.xcel_m),
    .i_trip, .i_trip_clr, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
    .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
    .i_rready, .o_run, .o_reverse, .o_drive_en, .o_search, .o_freq, .o_irq);
  // ==========================================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic exp_run(input logic [1:0] s, input logic f, input logic r);
    if (s == SRC_TERM_ONE) return f ^ r;
    if (s == SRC_TERM_TWO) return f;
    return 1'h0;
  endfunction : exp_run
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic near(input logic [15:0] e);
    n_tests++;
    if ((o_freq + 16'h0004 >= e && o_freq <= e + 16'h0004) !== 1'h1) begin
      n_fail++;
      $display("[ERR] freq expected %h seen %h", e, o_freq);
    end
  endtask : near
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  task automatic pins(input logic f, input logic r, input int n);
    fx_q <= f;
    rx_q <= r;
    tick(n);
  endtask : pins
  // address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= 4'hF;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'h0;
      if (o_wready) i_wvalid <= 1'h0;
    end while (!o_bvalid);
    rr = o_bresp;
    i_bready <= 1'h0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do begin
      @(posedge i_clk);
      if (o_arready) i_arvalid <= 1'h0;
    end while (!o_rvalid);
    rv = o_rdata;
    rr = o_rresp;
    i_rready <= 1'h0;
    tick(1);
  endtask : rd
  // ==========================================================================
  // clock and watchdog
  initial begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_search === 1'h1) n_srch <= n_srch + 1;
    if (cyc == 40000) begin
      n_fail++;
      summarize();
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    {i_nrst, i_trip, i_trip_clr, rx_q, sel_q} = 6'h00;
    fx_q = 1'h1;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
    seed = 32'h0001_7135;
    tick(4);
    i_nrst <= 1'h1;
    tick(2);
    rd(OFS_CTRL);
    chk("ctrl", {16'h0000, CTRL_RST}, rv);
    rd(OFS_TIME0);
    chk("time0", {16'h0000, TIME_RST}, rv);
    rd(8'h80);
    chk("resp", RESP_SLVERR, rr);
    chk("rdata", 32'h0000_0000, rv);
    wr(8'h80, 32'h0000_0000);
    chk("bresp", RESP_SLVERR, rr);
    // run held on through power-up is ignored until off then on
    tick(14);
    chk("run", 1'h0, o_run);
    pins(1'h0, 1'h0, 8);
    pins(1'h1, 1'h0, 10);
    chk("run", 1'h1, o_run);
    pins(1'h1, 1'h1, 10);
    chk("run", 1'h0, o_run);
    chk("reverse", 1'h1, o_reverse);
    for (int k = 0; k < 10; k++) begin
      seed = xs(seed);
      pins(1'h0, 1'h0, 8);
      wr(OFS_CTRL, {24'h0000, 6'h08, seed[1:0]});
      pins(seed[2], seed[3], 10);
      chk("run", exp_run(seed[1:0], seed[2], seed[3]), o_run);
    end
    // trip, masked or unmasked interrupt, reset with restart off and on
    for (int e = 0; e < 2; e++) begin
      wr(OFS_CTRL, {16'h0000, 8'h04, 3'h1, 1'h0, e[0], 3'h2});
      wr(OFS_IRQ_MASK, e);
      pins(1'h0, 1'h0, 6);
      pins(1'h1, 1'h0, 10);
      n0 = n_srch;
      i_trip <= 1'h1;
      tick(1);
      i_trip <= 1'h0;
      tick(3);
      chk("drive", 1'h0, o_drive_en);
      chk("irq", e[0], o_irq);
      rd(OFS_IRQ_STAT);
      chk("stat", 1'h1, rv[IRQ_TRIP]);
      tick(2);
      chk("irq", 1'h0, o_irq);
      chk("drive", 1'h0, o_drive_en);
      i_trip_clr <= 1'h1;
      tick(1);
      i_trip_clr <= 1'h0;
      tick(10);
      chk("run", e[0], o_run);
      chk("search", e, n_srch - n0);
      pins(1'h0, 1'h0, 8);
      pins(1'h1, 1'h0, 10);
      chk("run", 1'h1, o_run);
      chk("drive", 1'h1, o_drive_en);
    end
    // 0.6 lsb a cycle on the top basis, 0.06 on the step basis
    wr(OFS_CTRL, 32'h0000_0082);
    wr(OFS_TIME0, 32'h0000_0064);
    wr(OFS_TARGET, 32'h0000_0258);
    tick(500);
    near(16'h012C);
    tick(600);
    chk("freq", 16'h0258, o_freq);
    wr(OFS_CTRL, 32'h0000_0092);
    wr(OFS_TARGET, 32'h0000_04B0);
    tick(5000);
    near(16'h0384);
    tick(5200);
    chk("freq", 16'h04B0, o_freq);
    // unit change saturates, code 3 reads as 2
    wr(OFS_CTRL, 32'h0000_00A2);
    wr(OFS_TIME0, 32'h0000_03E8);
    wr(OFS_CTRL, 32'h0000_0082);
    rd(OFS_TIME0);
    chk("time0", {16'h0000, TIME_MAX}, rv);
    wr(OFS_CTRL, 32'h0000_00E2);
    rd(OFS_TIME0);
    chk("time0", 32'h0000_003C, rv);
    rd(OFS_CTRL);
    chk("ctrl", 32'h0000_00C2, rv);
    // select pins wait out a 50-cycle settle window
    wr(OFS_SETTLE, 32'h0000_0005);
    prev = 2'h0;
    for (int k = 1; k < 5; k++) begin
      sel_q <= k[1:0];
      tick(20);
      rd(OFS_STATUS);
      chk("set", prev, rv[9:8]);
      tick(60);
      rd(OFS_STATUS);
      chk("set", k[1:0], rv[7:6]);
      prev = k[1:0];
    end
    wr(OFS_CTRL, 32'h0000_0002);
    tick(60);
    rd(OFS_STATUS);
    chk("set", 2'h1, rv[7:6]);
    wr(OFS_SWITCH_FREQ, 32'h0000_03E8);
    tick(60);
    rd(OFS_STATUS);
    chk("set", 2'h0, rv[7:6]);
    // reset in mid-run with the run pin held: ignored by default, then power-on run with search
    i_nrst <= 1'h0;
    tick(2);
    i_nrst <= 1'h1;
    tick(12);
    chk("run", 1'h0, o_run);
    n0 = n_srch;
    wr(OFS_CTRL, 32'h0000_1025);
    tick(3);
    chk("run", 1'h1, o_run);
    chk("search", 1, n_srch - n0);
    summarize();
  end
endmodule : testbench
